// file: hdl/sicd_pkg.sv
// package for the simple interrupt controller: register map, control
// field layout, reset values and bus-side timing figures.
// assumes a word-aligned peripheral bus; offsets are byte addresses.
package sicd_pkg;

  localparam int unsigned SICD_MAX_WIDTH = 32;
  localparam int unsigned SICD_WINDOW_WORDS = 8;
  localparam int unsigned SICD_OFS_BITS = 5;

  localparam logic [4:0] SICD_OFS_STATUS = 5'h00;
  localparam logic [4:0] SICD_OFS_PENDING = 5'h04;
  localparam logic [4:0] SICD_OFS_ENABLE = 5'h08;
  localparam logic [4:0] SICD_OFS_ACK = 5'h0C;
  localparam logic [4:0] SICD_OFS_SET_EN = 5'h10;
  localparam logic [4:0] SICD_OFS_CLR_EN = 5'h14;
  localparam logic [4:0] SICD_OFS_VECTOR = 5'h18;
  localparam logic [4:0] SICD_OFS_CONTROL = 5'h1C;

  // global_control field positions
  localparam int unsigned SICD_CTL_OUT_EN_BIT = 0;
  localparam int unsigned SICD_CTL_HW_EN_BIT = 1;
  localparam logic [1:0] SICD_CTL_RESET = 2'h0;

  // reset value of the per-input registers, and the vector idle code
  localparam logic [31:0] SICD_REG_RESET = 32'h0000_0000;
  localparam logic [31:0] SICD_VECTOR_NONE = 32'hFFFF_FFFF;

  // answer comes a fixed number of clocks after the request is taken
  localparam int unsigned SICD_ACK_LATENCY = 1;

  // synchroniser depth in front of every edge-detected input
  localparam int unsigned SICD_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    SICD_BUS_IDLE = 2'h0,
    SICD_BUS_ANSWER = 2'h1
  } sicd_bus_state_type;

endpackage

// file: hdl/sicd_det_if.sv
// carrier between the controller core and its input detector.
// assumes both ends share clk_sys_in and sys_rst_in.
`timescale 1ns/1ps
`default_nettype none
interface sicd_det_if #(
  parameter int unsigned NUM_INTR = 32
);
  logic [NUM_INTR-1:0] raw;
  logic [NUM_INTR-1:0] event_hit;
  logic arm;

  modport detector (
    input raw,
    input arm,
    output event_hit
  );
  modport core (
    output raw,
    output arm,
    input event_hit
  );
endinterface
`default_nettype wire

// file: hdl/sicd_detect.sv
// per-input detector: level inputs pass straight through, edge inputs
// go through a two-stage synchroniser and a rising-edge catcher.
// assumes raw inputs may be asynchronous only where edge detection is set.
`timescale 1ns/1ps
`default_nettype none
module sicd_detect
  import sicd_pkg::*;
#(
  parameter int unsigned NUM_INTR = 32,
  parameter logic [31:0] EDGE_MASK = 32'h0000_0000
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  sicd_det_if.detector det
);

  logic [NUM_INTR-1:0] sync_first;
  logic [NUM_INTR-1:0] sync_second;
  logic [NUM_INTR-1:0] edge_prev;

  // first stage is read only by the second stage
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sync_first <= '0;
      sync_second <= '0;
    end else begin
      sync_first <= det.raw;
      sync_second <= sync_first;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      edge_prev <= '0;
    end else begin
      edge_prev <= sync_second;
    end
  end

  // edges are only caught while the hardware inputs are armed
  always_comb begin
    for (int i = 0; i < NUM_INTR; i++) begin
      if (EDGE_MASK[i]) begin
        det.event_hit[i] = det.arm & sync_second[i] & ~edge_prev[i];
      end else begin
        det.event_hit[i] = det.arm & det.raw[i];
      end
    end
  end

endmodule
`default_nettype wire

// file: hdl/sicd_top.sv
// simple interrupt controller: status, pending, enable, acknowledge,
// set/clear enable strobes, priority index and global control behind a
// byte-enabled peripheral bus slave, driving one request output.
// the input detector sits in sicd_detect, reached through sicd_det_if.
// assumes a single bus master, one request outstanding at a time, and
// big-endian lane numbering (lane 0 carries the most significant byte).
`timescale 1ns/1ps
`default_nettype none
module sicd_top
  import sicd_pkg::*;
#(
  parameter int unsigned DATA_WIDTH = 32,
  parameter int unsigned NUM_INTR = 32,
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000,
  parameter logic [31:0] EDGE_MASK = 32'h0000_0000,
  parameter bit REQ_PULSE = 1'b0,
  parameter bit HAS_PENDING = 1'b1,
  parameter bit HAS_SET_EN = 1'b1,
  parameter bit HAS_CLR_EN = 1'b1,
  parameter bit HAS_VECTOR = 1'b1
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [NUM_INTR-1:0] intr_in,
  input wire logic bus_select_in,
  input wire logic bus_read_not_write_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic [DATA_WIDTH/8-1:0] bus_byte_en_in,
  input wire logic [DATA_WIDTH-1:0] bus_wdata_in,
  output logic [DATA_WIDTH-1:0] bus_rdata_out,
  output logic bus_xfer_ack_out,
  output logic irq_out
);

  localparam int unsigned LANES = DATA_WIDTH / 8;

  // limitation: only bus widths of 8, 16 and 32 bits and 1 to DATA_WIDTH
  // inputs are meaningful; nothing refuses another choice at build time,
  // so the integrator must keep to them

  // expand byte enables to a bit mask; lane 0 is the top byte
  function automatic logic [DATA_WIDTH-1:0] lane_mask(
    input logic [LANES-1:0] be
  );
    logic [DATA_WIDTH-1:0] m;
    m = '0;
    for (int l = 0; l < LANES; l++) begin
      for (int b = 0; b < 8; b++) begin
        m[DATA_WIDTH - 8 - 8 * l + b] = be[l];
      end
    end
    return m;
  endfunction

  // index of the lowest set bit; the caller checks for an empty vector
  function automatic logic [DATA_WIDTH-1:0] lowest_index(
    input logic [NUM_INTR-1:0] v
  );
    logic [DATA_WIDTH-1:0] idx;
    logic found;
    idx = '0;
    found = 1'b0;
    for (int i = 0; i < NUM_INTR; i++) begin
      if (v[i] && !found) begin
        idx = DATA_WIDTH'(i);
        found = 1'b1;
      end
    end
    return idx;
  endfunction

  // place the per-input bits at the bottom, unused bits read zero
  function automatic logic [DATA_WIDTH-1:0] widen(
    input logic [NUM_INTR-1:0] v
  );
    logic [DATA_WIDTH-1:0] w;
    w = '0;
    w[NUM_INTR-1:0] = v;
    return w;
  endfunction

  sicd_det_if #(.NUM_INTR(NUM_INTR)) det_link ();

  logic [NUM_INTR-1:0] interrupt_status;
  logic [NUM_INTR-1:0] interrupt_enable;
  logic [1:0] global_control;
  logic [NUM_INTR-1:0] interrupt_pending;
  logic request_level;
  logic request_prev;

  sicd_bus_state_type bus_state;
  logic in_window;
  logic [SICD_OFS_BITS-1:0] offset;
  logic take;
  logic wr_take;
  logic [DATA_WIDTH-1:0] wr_bits;
  logic [NUM_INTR-1:0] wr_in_bits;
  logic [DATA_WIDTH-1:0] next_rdata;
  logic [DATA_WIDTH-1:0] rdata;
  logic [DATA_WIDTH-1:0] byte_mask;
  logic wr_status;
  logic wr_ack;
  logic wr_enable;
  logic wr_set_en;
  logic wr_clr_en;
  logic wr_control;
  logic rd_take;
  logic [NUM_INTR-1:0] status_set;
  logic [NUM_INTR-1:0] status_clr;
  logic [NUM_INTR-1:0] next_status;
  logic [NUM_INTR-1:0] next_enable;
  logic [1:0] next_control;

  logic hw_enabled;
  logic out_enabled;

  assign hw_enabled = global_control[SICD_CTL_HW_EN_BIT];
  assign out_enabled = global_control[SICD_CTL_OUT_EN_BIT];

  assign det_link.raw = intr_in;
  assign det_link.arm = hw_enabled;

  sicd_detect #(
    .NUM_INTR(NUM_INTR),
    .EDGE_MASK(EDGE_MASK)
  ) detect_inst (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .det(det_link.detector)
  );

  // window decode; the low two address bits are ignored
  assign in_window = (bus_addr_in[31:SICD_OFS_BITS]
                      == BASE_ADDR[31:SICD_OFS_BITS]);
  assign offset = {bus_addr_in[SICD_OFS_BITS-1:2], 2'b00};
  assign take = bus_select_in && in_window
                && (bus_state == SICD_BUS_IDLE);
  assign wr_take = take && !bus_read_not_write_in;
  assign rd_take = take && bus_read_not_write_in;
  // one mask keeps disabled lanes out of every read and every write except control, which tests the bottom lane's enable itself
  assign byte_mask = lane_mask(bus_byte_en_in);
  assign wr_bits = bus_wdata_in & byte_mask;
  assign wr_in_bits = wr_bits[NUM_INTR-1:0];

  // write strobes, one per location; removed strobes never fire
  assign wr_status = wr_take && (offset == SICD_OFS_STATUS);
  assign wr_ack = wr_take && (offset == SICD_OFS_ACK);
  assign wr_enable = wr_take && (offset == SICD_OFS_ENABLE);
  assign wr_set_en = HAS_SET_EN && wr_take
                     && (offset == SICD_OFS_SET_EN);
  assign wr_clr_en = HAS_CLR_EN && wr_take
                     && (offset == SICD_OFS_CLR_EN);
  assign wr_control = wr_take && (offset == SICD_OFS_CONTROL)
                      && bus_byte_en_in[LANES-1];

  // one request in flight: the acknowledge cycle blocks a new take
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      bus_state <= SICD_BUS_IDLE;
    end else begin
      unique case (bus_state)
        SICD_BUS_IDLE: begin
          if (take) begin
            bus_state <= SICD_BUS_ANSWER;
          end
        end
        SICD_BUS_ANSWER: begin
          bus_state <= SICD_BUS_IDLE;
        end
        default: begin
          bus_state <= SICD_BUS_IDLE;
        end
      endcase
    end
  end

  assign bus_xfer_ack_out = (bus_state == SICD_BUS_ANSWER);

  // status: hardware and software sets win over an acknowledge clear
  // a level input held high sets its bit again every cycle, so an
  // acknowledge only sticks once the source has dropped
  always_comb begin
    status_set = det_link.event_hit;
    status_clr = '0;
    if (wr_status && !hw_enabled) begin
      status_set = status_set | wr_in_bits;
    end
    if (wr_ack) begin
      status_clr = wr_in_bits;
    end
    next_status = (interrupt_status & ~status_clr) | status_set;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      interrupt_status <= SICD_REG_RESET[NUM_INTR-1:0];
    end else begin
      interrupt_status <= next_status;
    end
  end

  // enable: plain write per lane, plus optional set and clear strobes
  always_comb begin
    next_enable = interrupt_enable;
    if (wr_enable) begin
      next_enable = (interrupt_enable & ~byte_mask[NUM_INTR-1:0])
                    | wr_in_bits;
    end else if (wr_set_en) begin
      next_enable = interrupt_enable | wr_in_bits;
    end else if (wr_clr_en) begin
      next_enable = interrupt_enable & ~wr_in_bits;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      interrupt_enable <= SICD_REG_RESET[NUM_INTR-1:0];
    end else begin
      interrupt_enable <= next_enable;
    end
  end

  // hardware enable can be set by software but only reset clears it
  always_comb begin
    next_control = global_control;
    if (wr_control) begin
      next_control[SICD_CTL_OUT_EN_BIT] =
        bus_wdata_in[SICD_CTL_OUT_EN_BIT];
      next_control[SICD_CTL_HW_EN_BIT] =
        hw_enabled | bus_wdata_in[SICD_CTL_HW_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      global_control <= SICD_CTL_RESET;
    end else begin
      global_control <= next_control;
    end
  end

  // masking never touches status, so re-enabling requests at once
  assign interrupt_pending = interrupt_status & interrupt_enable;
  assign request_level = out_enabled && (|interrupt_pending);

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      request_prev <= 1'b0;
    end else begin
      request_prev <= request_level;
    end
  end

  // pulse mode gives one clock per rise; level mode holds until cleared
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else if (REQ_PULSE) begin
      irq_out <= request_level && !request_prev;
    end else begin
      irq_out <= request_level;
    end
  end

  // read mux; write-only and removed locations read zero
  always_comb begin
    next_rdata = '0;
    unique case (offset)
      SICD_OFS_STATUS: begin
        next_rdata = widen(interrupt_status);
      end
      SICD_OFS_PENDING: begin
        if (HAS_PENDING) begin
          next_rdata = widen(interrupt_pending);
        end
      end
      SICD_OFS_ENABLE: begin
        next_rdata = widen(interrupt_enable);
      end
      SICD_OFS_VECTOR: begin
        if (HAS_VECTOR) begin
          if (|interrupt_pending) begin
            next_rdata = lowest_index(interrupt_pending);
          end else begin
            next_rdata = SICD_VECTOR_NONE[DATA_WIDTH-1:0];
          end
        end
      end
      SICD_OFS_CONTROL: begin
        next_rdata[1:0] = global_control;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // read data is registered and only shown during the acknowledge
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rdata <= '0;
    end else if (rd_take) begin
      rdata <= next_rdata & byte_mask;
    end else begin
      rdata <= '0;
    end
  end

  assign bus_rdata_out = rdata;

endmodule
`default_nettype wire

// file: dv/sicd_chk.sv
// checker: bus answer timing and read-data shape of the controller
// assumes the bind below attaches it to every sicd_top instance
`timescale 1ns/1ps
`default_nettype none
module sicd_chk
  import sicd_pkg::*;
#(
  parameter int unsigned DATA_WIDTH = 32,
  parameter int unsigned NUM_INTR = 32,
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [NUM_INTR-1:0] intr_in,
  input wire logic bus_select_in,
  input wire logic bus_read_not_write_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic [DATA_WIDTH/8-1:0] bus_byte_en_in,
  input wire logic [DATA_WIDTH-1:0] bus_wdata_in,
  input wire logic [DATA_WIDTH-1:0] bus_rdata_out,
  input wire logic bus_xfer_ack_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic hit;
  logic away;
  logic rd_q;
  logic msb_q;
  logic full_q;
  logic [2:0] loc_q;
  assign hit = bus_select_in && bus_addr_in[31:5] == BASE_ADDR[31:5];
  assign away = bus_select_in && bus_addr_in[31:5] != BASE_ADDR[31:5];
  // request fields as seen at the take edge, used in the answer cycle
  always_ff @(posedge clk_sys_in) begin
    rd_q <= bus_read_not_write_in;
    msb_q <= bus_byte_en_in[0];
    full_q <= &bus_byte_en_in;
    loc_q <= bus_addr_in[4:2];
  end
  ack_next_a: assert property (
    hit && !bus_xfer_ack_out |=> bus_xfer_ack_out)
    else $error("request in window not answered next cycle");
  outside_quiet_a: assert property (away |=> !bus_xfer_ack_out)
    else $error("request outside window answered");
  ack_pulse_a: assert property (bus_xfer_ack_out |=> !bus_xfer_ack_out)
    else $error("answer longer than one cycle");
  rdata_idle_a: assert property (
    !(bus_xfer_ack_out && rd_q) |-> bus_rdata_out == '0)
    else $error("read data outside a read answer");
  lane_masked_a: assert property (bus_xfer_ack_out && !msb_q
    |-> bus_rdata_out[DATA_WIDTH-1 -: 8] == 8'h00)
    else $error("disabled top lane carries data");
  ack_loc_zero_a: assert property (bus_xfer_ack_out && rd_q
    && loc_q == 3'h3 |-> bus_rdata_out == '0)
    else $error("acknowledge location returned data");
  spare_bits_a: assert property (bus_xfer_ack_out && loc_q <= 3'h2
    |-> (bus_rdata_out >> NUM_INTR) == '0)
    else $error("bit without an input reads one");
  ctl_width_a: assert property (bus_xfer_ack_out && loc_q == 3'h7
    |-> bus_rdata_out[DATA_WIDTH-1:2] == '0)
    else $error("control reads beyond two bits");
  vector_range_a: assert property (bus_xfer_ack_out && rd_q && full_q
    && loc_q == 3'h6 |-> bus_rdata_out < NUM_INTR
    || bus_rdata_out == SICD_VECTOR_NONE[DATA_WIDTH-1:0])
    else $error("index out of range");
  cover property (hit && bus_read_not_write_in);
  cover property (hit && !bus_read_not_write_in);
  cover property ($rose(irq_out));
endmodule
bind sicd_top sicd_chk #(.DATA_WIDTH(DATA_WIDTH), .NUM_INTR(NUM_INTR),
  .BASE_ADDR(BASE_ADDR)) sicd_chk_inst (.clk_sys_in, .sys_rst_in,
  .intr_in, .bus_select_in, .bus_read_not_write_in, .bus_addr_in,
  .bus_byte_en_in, .bus_wdata_in, .bus_rdata_out, .bus_xfer_ack_out,
  .irq_out);
`default_nettype wire

// file: dv/sicd_master.sv
// processor-side bus master model: one word per access, with the byte enables the caller gives
// assumes the slave answers within a few clocks or not at all
`timescale 1ns/1ps
`default_nettype none
module sicd_master (
  input wire logic clk_sys_in,
  output logic sel_out,
  output logic rnw_out,
  output logic [31:0] addr_out,
  output logic [3:0] be_out,
  output logic [31:0] wdata_out,
  input wire logic [31:0] rdata_in,
  input wire logic ack_in
);
  initial begin
    sel_out = 1'b0;
    rnw_out = 1'b0;
    addr_out = 32'h0;
    be_out = 4'h0;
    wdata_out = 32'h0;
  end
  task automatic xfer(input logic r, input logic [31:0] a,
    input logic [3:0] b, input logic [31:0] d,
    output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q = 32'h0;
    @(posedge clk_sys_in);
    sel_out <= 1'b1;
    rnw_out <= r;
    addr_out <= a;
    be_out <= b;
    wdata_out <= d;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk_sys_in);
      if (ack_in === 1'b1) begin
        ok = 1'b1;
        q = rdata_in;
      end
    end
    // inverted leftovers so a stale value never looks valid
    sel_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// testbench: register-level tests of the interrupt controller
// assumes the bus master model and a 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sicd_pkg::*;
;
  localparam logic [31:0] BASE = 32'h0000_0100;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] intr = 8'h00;
  logic sel, rnw, ack, irq, irq_pulse, ok;
  logic [31:0] addr, wdata, rdata, q;
  logic [3:0] be;
  int miscompares = 0;
  int n_compared = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  // input 1 is edge detected, the others by level
  sicd_top #(.NUM_INTR(8), .BASE_ADDR(BASE), .EDGE_MASK(32'h0000_0002))
  sicd_top_inst (.clk_sys_in, .sys_rst_in, .intr_in(intr),
    .bus_select_in(sel), .bus_read_not_write_in(rnw), .bus_addr_in(addr),
    .bus_byte_en_in(be), .bus_wdata_in(wdata), .bus_rdata_out(rdata),
    .bus_xfer_ack_out(ack), .irq_out(irq));
  sicd_master sicd_master_inst (.clk_sys_in, .sel_out(sel),
    .rnw_out(rnw), .addr_out(addr), .be_out(be), .wdata_out(wdata),
    .rdata_in(rdata), .ack_in(ack));
  // a pulse-mode twin on the same bus; only its request output is watched
  if (1'b1) begin : g_pulse
    sicd_top #(.NUM_INTR(8), .BASE_ADDR(BASE), .EDGE_MASK(32'h0000_0002),
      .REQ_PULSE(1'b1))
    sicd_top_inst (.clk_sys_in, .sys_rst_in, .intr_in(intr),
      .bus_select_in(sel), .bus_read_not_write_in(rnw), .bus_addr_in(addr),
      .bus_byte_en_in(be), .bus_wdata_in(wdata), .bus_rdata_out(),
      .bus_xfer_ack_out(), .irq_out(irq_pulse));
  end
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(logic r, logic [4:0] o, logic [3:0] b,
    logic [31:0] d);
    sicd_master_inst.xfer(r, BASE | {27'h0, o}, b, d, q, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD answer at %h expected 1 seen %b", o, ok);
      end_sim();
    end
  endtask
  task automatic wr(logic [4:0] o, logic [31:0] d, logic [3:0] b = 4'hF);
    acc(1'b0, o, b, d);
  endtask
  task automatic rd(logic [4:0] o, logic [31:0] e, logic [3:0] b = 4'hF);
    acc(1'b1, o, b, 32'h0);
    chk($sformatf("offset %h", o), q, e);
  endtask
  task automatic ci(logic e);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  initial begin
    cyc(8);
    sys_rst_in <= 1'b0;
    rd(5'h00, 32'h0);
    rd(5'h04, 32'h0);
    rd(5'h08, 32'h0);
    rd(5'h1C, 32'h0);
    rd(5'h18, SICD_VECTOR_NONE);
    wr(5'h00, 32'hFFFF_FF05);
    rd(5'h00, 32'h05);
    wr(5'h08, 32'h0000_0104);
    rd(5'h08, 32'h04);
    rd(5'h04, 32'h04);
    rd(5'h18, 32'h2);
    ci(1'b0);
    wr(5'h1C, 32'h1);
    cyc(1);
    chk("pulse", {31'h0, irq_pulse}, 32'h1);
    cyc(1);
    ci(1'b1);
    chk("pulse", {31'h0, irq_pulse}, 32'h0);
    wr(5'h10, 32'h1);
    rd(5'h08, 32'h05);
    rd(5'h18, 32'h0);
    wr(5'h14, 32'h05);
    rd(5'h08, 32'h0);
    cyc(2);
    ci(1'b0);
    rd(5'h00, 32'h05);
    wr(5'h10, 32'h04);
    cyc(2);
    ci(1'b1);
    wr(5'h0C, 32'h04);
    cyc(2);
    ci(1'b0);
    rd(5'h00, 32'h01);
    rd(5'h0C, 32'h0);
    // lane 3 holds bits 7:0, so a write without it leaves them alone
    wr(5'h08, 32'hFFFF_FFFF, 4'h7);
    rd(5'h08, 32'h04);
    wr(5'h08, 32'h01, 4'h8);
    rd(5'h08, 32'h01);
    rd(5'h00, 32'h0, 4'h7);
    wr(5'h1C, 32'h3);
    wr(5'h1C, 32'h1);
    rd(5'h1C, 32'h3);
    wr(5'h0C, 32'h1);
    wr(5'h00, 32'h2);
    rd(5'h00, 32'h0);
    wr(5'h08, 32'h3);
    intr <= 8'h03;
    cyc(6);
    rd(5'h00, 32'h03);
    wr(5'h0C, 32'h03);
    rd(5'h00, 32'h01);
    intr <= 8'h00;
    wr(5'h0C, 32'h01);
    rd(5'h00, 32'h0);
    sicd_master_inst.xfer(1'b1, BASE + 32'h20, 4'hF, 32'h0, q, ok);
    chk("outside", {31'h0, ok}, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
